//--- swp_strap_cfg.sv
// Purpose: strap-pin configuration of a 4:1 video link switch with APB override.
// Assumes: straps static and synchronous; APB master holds requests until pready.
// Notes:   any completed access to a mapped register ends strap mode until reset.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module swp_strap_cfg
(
	input  wire logic                           ref_clk,
	input  wire logic                           rst_n,
	input  wire logic                           hs_channel_enable_strap,
	input  wire logic [1:0]                     source_select_strap,
	input  wire logic                           equalizer_level_strap,
	input  wire logic [1:0]                     preemphasis_level_strap,
	input  wire logic                           output_termination_strap,
	input  wire logic                           output_current_strap,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [swp_pkg::APB_AW-1:0]     paddr,
	input  wire logic [swp_pkg::DW-1:0]         pwdata,
	input  wire logic [swp_pkg::NUM_BYTE-1:0]   pstrb,
	output wire logic [swp_pkg::DW-1:0]         prdata,
	output wire logic                           pready,
	output wire logic                           pslverr,
	output wire logic                           strapModeActive,
	output wire logic                           hsChannelEnable,
	output wire logic                           standbyMode,
	output wire logic [swp_pkg::NUM_SRC-1:0]    hsSourceSelect,
	output wire logic [swp_pkg::NUM_SRC-1:0]    auxCommonPortSel,
	output wire logic                           auxSwitchEnable,
	output wire logic                           inputTermOn,
	output wire logic [swp_pkg::NUM_SRC-1:0]    termPulseEnable,
	output wire logic [swp_pkg::NUM_LANE-1:0]   eqHighLane,
	output wire logic [1:0]                     preEmphasisLevel,
	output wire logic                           outputTermOn,
	output wire logic                           outputCurrentHigh
);

	swp_pkg::swp_top_t            q;
	swp_pkg::swp_top_t            d;
	swp_pkg::swp_cfg_t            view;
	logic [swp_pkg::DW-1:0]       ctrlWord;
	logic [swp_pkg::DW-1:0]       statWord;
	logic [swp_pkg::DW-1:0]       rdValue;
	logic [swp_pkg::DW-1:0]       byteMask;
	logic [swp_pkg::DW-1:0]       merged;
	logic                         hitCtrl;
	logic                         hitStat;
	logic                         hit;
	logic                         accessPh;
	logic                         strapOn;

	swp_cfg_if strapIf ();
	swp_cfg_if effIf ();

	// -------------------------------------------------------
	// strap decode
	// -------------------------------------------------------
	swp_strap_decode u_decode
	(
		.hs_channel_enable_strap  (hs_channel_enable_strap),
		.source_select_strap      (source_select_strap),
		.equalizer_level_strap    (equalizer_level_strap),
		.preemphasis_level_strap  (preemphasis_level_strap),
		.output_termination_strap (output_termination_strap),
		.output_current_strap     (output_current_strap),
		.strapCfg                 (strapIf)
	);

	// -------------------------------------------------------
	// effective configuration
	// -------------------------------------------------------
	assign strapOn = (q.mode == swp_pkg::MODE_STRAP);

	// straps are read live, so a strap edit shows without a reset
	assign view      = strapOn ? strapIf.cfg : q.ctrl;
	assign effIf.cfg = view;

	assign ctrlWord = {{(swp_pkg::DW - swp_pkg::CFG_W){1'h0}}, view};

	always_comb
	begin
		statWord                                                = swp_pkg::WORD_ZERO;
		statWord[swp_pkg::STAT_MODE_BIT]                        = strapOn;
		statWord[swp_pkg::STAT_CFG_LSB +: swp_pkg::CFG_W]       = view;
	end

	// -------------------------------------------------------
	// apb decode
	// -------------------------------------------------------
	assign accessPh = psel & penable;
	assign hitCtrl  = (paddr == swp_pkg::OFS_CTRL);
	assign hitStat  = (paddr == swp_pkg::OFS_STATUS);
	assign hit      = hitCtrl | hitStat;

	always_comb
	begin
		rdValue = swp_pkg::WORD_ZERO;
		if (hitCtrl)
			rdValue = ctrlWord;
		else if (hitStat)
			rdValue = statWord;
	end

	// byte strobes only touch the lanes they name
	always_comb
	begin
		byteMask = swp_pkg::WORD_ZERO;
		for (int b = 0; b < swp_pkg::NUM_BYTE; b++)
		begin
			byteMask[b*8 +: 8] = {8{pstrb[b]}};
		end
		merged = (ctrlWord & ~byteMask) | (pwdata & byteMask);
	end

	// -------------------------------------------------------
	// register state
	// -------------------------------------------------------
	// one wait state: the first access cycle samples read data into a
	// flop, the second raises pready; writes land on the pready edge
	always_comb
	begin
		d        = q;
		d.ready  = 1'h0;
		d.slverr = 1'h0;
		if (accessPh && !q.ready)
		begin
			d.ready  = 1'h1;
			d.slverr = ~hit;
			d.rdata  = rdValue;
		end
		if (accessPh && q.ready && hit)
		begin
			// first mapped access hands control to software until reset
			d.mode = swp_pkg::MODE_SERIAL;
			if (pwrite && hitCtrl)
				d.ctrl = swp_pkg::swp_cfg_t'(merged[swp_pkg::CFG_W-1:0]);
			else if (strapOn)
				d.ctrl = view; // seamless takeover keeps strap values
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			q <= swp_pkg::TOP_RST;
		else
			q <= d;
	end

	assign prdata          = q.rdata;
	assign pready          = q.ready;
	assign pslverr         = q.slverr & q.ready;
	assign strapModeActive = strapOn;

	// -------------------------------------------------------
	// output drive
	// -------------------------------------------------------
	swp_out_drive u_drive
	(
		.ref_clk           (ref_clk),
		.rst_n             (rst_n),
		.effCfg            (effIf),
		.hsChannelEnable   (hsChannelEnable),
		.standbyMode       (standbyMode),
		.hsSourceSelect    (hsSourceSelect),
		.auxCommonPortSel  (auxCommonPortSel),
		.auxSwitchEnable   (auxSwitchEnable),
		.inputTermOn       (inputTermOn),
		.termPulseEnable   (termPulseEnable),
		.eqHighLane        (eqHighLane),
		.preEmphasisLevel  (preEmphasisLevel),
		.outputTermOn      (outputTermOn),
		.outputCurrentHigh (outputCurrentHigh)
	);

	// -------------------------------------------------------
	// assertions
	// -------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	AST_STANDBY: assert property (
		strapOn |=> (standbyMode == ~$past(hs_channel_enable_strap))
			&& (hsChannelEnable == $past(hs_channel_enable_strap)))
		else $error("standby does not follow channel enable strap");

	AST_SOURCE_ROUTE: assert property (
		strapOn |=> hsSourceSelect == (4'h1 << $past(source_select_strap)))
		else $error("high speed source does not follow source strap");

	AST_AUX_ROUTE: assert property (
		strapOn |=> auxCommonPortSel == (4'h1 << $past(source_select_strap)))
		else $error("aux source differs from high speed source");

	AST_AUX_ENABLE: assert property (
		strapOn [*2] |-> auxSwitchEnable)
		else $error("aux switch off in strap mode");

	AST_IN_TERM: assert property (
		strapOn |=> inputTermOn)
		else $error("input termination off in strap mode");

	AST_NO_PULSE: assert property (
		strapOn |=> termPulseEnable == 4'h0)
		else $error("termination pulse on in strap mode");

	AST_EQ_ALL: assert property (
		strapOn |=> eqHighLane == {16{$past(equalizer_level_strap)}})
		else $error("equalizer lanes differ from equalizer strap");

	AST_PREEMPH: assert property (
		strapOn |=> preEmphasisLevel == $past(preemphasis_level_strap))
		else $error("pre-emphasis does not follow strap");

	AST_OUT_TERM: assert property (
		strapOn |=> outputTermOn == $past(output_termination_strap))
		else $error("output termination does not follow strap");

	AST_OUT_CURRENT: assert property (
		strapOn |=> outputCurrentHigh == $past(output_current_strap))
		else $error("output current does not follow strap");

	AST_TAKEOVER: assert property (
		(psel && penable && pready && hit) |=> !strapModeActive [*3])
		else $error("strap mode survived a register access");

	AST_STAY_SERIAL: assert property (
		!strapModeActive |=> !strapModeActive)
		else $error("strap mode returned without reset");

	AST_APB_WAIT: assert property (
		(psel && penable && !pready) |=> pready && (prdata == $past(rdValue)))
		else $error("apb answer not one wait state");

endmodule

//--- swp_pkg.sv
// Purpose: shared constants and types of the strap configuration block.
// Assumes: one 10 MHz clock, APB register access with 32-bit data.
// Notes:   the cfg struct layout is also the CTRL register layout.
package swp_pkg;

	localparam int unsigned APB_AW   = 12;
	localparam int unsigned DW       = 32;
	localparam int unsigned CFG_W    = 11;
	localparam int unsigned NUM_SRC  = 4;
	localparam int unsigned NUM_LANE = 16;
	localparam int unsigned NUM_BYTE = 4;

	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;

	localparam int unsigned STAT_MODE_BIT = 0;
	localparam int unsigned STAT_CFG_LSB  = 16;

	localparam logic FORCED_AUX_EN     = 1'h1;
	localparam logic FORCED_IN_TERM    = 1'h1;
	localparam logic FORCED_TERM_PULSE = 1'h0;

	localparam logic [3:0]    ONEHOT_BASE = 4'h1;
	localparam logic [DW-1:0] WORD_ZERO   = 32'h0000_0000;

	typedef enum logic [1:0] {
		SRC_A = 2'h0,
		SRC_B = 2'h1,
		SRC_C = 2'h2,
		SRC_D = 2'h3
	} swp_src_t;

	typedef enum logic [1:0] {
		PE_0DB = 2'h0,
		PE_2DB = 2'h1,
		PE_4DB = 2'h2,
		PE_6DB = 2'h3
	} swp_pe_t;

	typedef enum logic {
		EQ_6DB  = 1'h0,
		EQ_12DB = 1'h1
	} swp_eq_t;

	typedef enum logic {
		OCL_10MA = 1'h0,
		OCL_20MA = 1'h1
	} swp_ocl_t;

	typedef enum logic {
		MODE_STRAP  = 1'h0,
		MODE_SERIAL = 1'h1
	} swp_mode_t;

	typedef struct packed {
		logic     termPulse;
		logic     inTerm;
		logic     auxEnable;
		swp_ocl_t outCurrent;
		logic     outTerm;
		swp_pe_t  preEmph;
		swp_eq_t  eqLevel;
		swp_src_t source;
		logic     hsEnable;
	} swp_cfg_t;

	localparam swp_cfg_t CFG_RST = 11'h000;

	typedef struct packed {
		logic                hsEnable;
		logic                standby;
		logic [NUM_SRC-1:0]  hsOneHot;
		logic [NUM_SRC-1:0]  auxOneHot;
		logic                auxEnable;
		logic                inTerm;
		logic [NUM_SRC-1:0]  termPulse;
		logic [NUM_LANE-1:0] eqHigh;
		logic [1:0]          preEmph;
		logic                outTerm;
		logic                outCurHigh;
	} swp_drive_t;

	localparam swp_drive_t DRIVE_RST = 36'h0_0000_0000;

	typedef struct packed {
		swp_mode_t     mode;
		swp_cfg_t      ctrl;
		logic          ready;
		logic          slverr;
		logic [DW-1:0] rdata;
	} swp_top_t;

	localparam swp_top_t TOP_RST = 46'h0000_0000_0000;

endpackage

//--- swp_cfg_if.sv
// Purpose: carries one decoded configuration between block modules.
// Assumes: single clock domain, no handshake needed.
// Notes:   src drives, dst listens.
`timescale 1ns/100ps
interface swp_cfg_if;
	swp_pkg::swp_cfg_t cfg;
	modport src (output cfg);
	modport dst (input cfg);
endinterface

//--- swp_strap_decode.sv
// Purpose: turns the strap pin levels into a configuration word.
// Assumes: strap pins are static levels, synchronous to ref_clk.
// Notes:   purely combinational, so strap edits follow at once.
`timescale 1ns/100ps
module swp_strap_decode
(
	input  wire logic hs_channel_enable_strap,
	input  wire logic [1:0] source_select_strap,
	input  wire logic equalizer_level_strap,
	input  wire logic [1:0] preemphasis_level_strap,
	input  wire logic output_termination_strap,
	input  wire logic output_current_strap,
	swp_cfg_if.src    strapCfg
);

	always_comb
	begin
		strapCfg.cfg            = swp_pkg::CFG_RST;
		strapCfg.cfg.hsEnable   = hs_channel_enable_strap;
		strapCfg.cfg.source     = swp_pkg::swp_src_t'(source_select_strap);
		strapCfg.cfg.eqLevel    = swp_pkg::swp_eq_t'(equalizer_level_strap);
		strapCfg.cfg.preEmph    = swp_pkg::swp_pe_t'(preemphasis_level_strap);
		strapCfg.cfg.outTerm    = output_termination_strap;
		strapCfg.cfg.outCurrent = swp_pkg::swp_ocl_t'(output_current_strap);
		strapCfg.cfg.auxEnable  = swp_pkg::FORCED_AUX_EN;
		strapCfg.cfg.inTerm     = swp_pkg::FORCED_IN_TERM;
		strapCfg.cfg.termPulse  = swp_pkg::FORCED_TERM_PULSE;
	end

endmodule

//--- swp_out_drive.sv
// Purpose: registers the effective configuration onto the analog controls.
// Assumes: cfg is valid every cycle; one cycle of latency is acceptable.
// Notes:   per-lane and per-source fan-out happens here.
`timescale 1ns/100ps
module swp_out_drive
(
	input  wire logic                            ref_clk,
	input  wire logic                            rst_n,
	swp_cfg_if.dst                               effCfg,
	output wire logic                            hsChannelEnable,
	output wire logic                            standbyMode,
	output wire logic [swp_pkg::NUM_SRC-1:0]     hsSourceSelect,
	output wire logic [swp_pkg::NUM_SRC-1:0]     auxCommonPortSel,
	output wire logic                            auxSwitchEnable,
	output wire logic                            inputTermOn,
	output wire logic [swp_pkg::NUM_SRC-1:0]     termPulseEnable,
	output wire logic [swp_pkg::NUM_LANE-1:0]    eqHighLane,
	output wire logic [1:0]                      preEmphasisLevel,
	output wire logic                            outputTermOn,
	output wire logic                            outputCurrentHigh
);

	swp_pkg::swp_drive_t               q;
	swp_pkg::swp_drive_t               d;
	logic [swp_pkg::NUM_LANE-1:0]      eqFan;
	logic [swp_pkg::NUM_SRC-1:0]       pulseFan;

	// -------------------------------------------------------
	// fan-out
	// -------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < swp_pkg::NUM_LANE; gi++)
		begin : g_lane
			// one setting for every lane; no per-channel control here
			assign eqFan[gi] = (effCfg.cfg.eqLevel == swp_pkg::EQ_12DB);
			if (gi < swp_pkg::NUM_SRC)
			begin : g_src
				assign pulseFan[gi] = effCfg.cfg.termPulse;
			end
		end
	endgenerate

	// -------------------------------------------------------
	// state
	// -------------------------------------------------------
	always_comb
	begin
		d            = q;
		d.hsEnable   = effCfg.cfg.hsEnable;
		d.standby    = ~effCfg.cfg.hsEnable;
		d.hsOneHot   = swp_pkg::ONEHOT_BASE << effCfg.cfg.source;
		d.auxOneHot  = swp_pkg::ONEHOT_BASE << effCfg.cfg.source;
		d.auxEnable  = effCfg.cfg.auxEnable;
		d.inTerm     = effCfg.cfg.inTerm;
		d.termPulse  = pulseFan;
		d.eqHigh     = eqFan;
		d.preEmph    = effCfg.cfg.preEmph;
		d.outTerm    = effCfg.cfg.outTerm;
		d.outCurHigh = (effCfg.cfg.outCurrent == swp_pkg::OCL_20MA);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			q <= swp_pkg::DRIVE_RST;
		else
			q <= d;
	end

	assign hsChannelEnable   = q.hsEnable;
	assign standbyMode       = q.standby;
	assign hsSourceSelect    = q.hsOneHot;
	assign auxCommonPortSel  = q.auxOneHot;
	assign auxSwitchEnable   = q.auxEnable;
	assign inputTermOn       = q.inTerm;
	assign termPulseEnable   = q.termPulse;
	assign eqHighLane        = q.eqHigh;
	assign preEmphasisLevel  = q.preEmph;
	assign outputTermOn      = q.outTerm;
	assign outputCurrentHigh = q.outCurHigh;

endmodule

//--- swp_strap_board.sv
// Purpose: board side of the strap pins, each tied to a fixed level.
// Assumes: tieLevel is changed only by the bench, between observations.
// Notes:   bit order matches the CTRL low byte to keep the bench model short.
`timescale 1ns/100ps
module swp_strap_board
(
	input  wire logic [7:0] tieLevel,
	output wire logic       hs_channel_enable_strap,
	output wire logic [1:0] source_select_strap,
	output wire logic       equalizer_level_strap,
	output wire logic [1:0] preemphasis_level_strap,
	output wire logic       output_termination_strap,
	output wire logic       output_current_strap
);
	// --------------------------------------------------------------
	// static ties, never floating
	// --------------------------------------------------------------
	assign hs_channel_enable_strap  = tieLevel[0];
	assign source_select_strap      = tieLevel[2:1];
	assign equalizer_level_strap    = tieLevel[3];
	assign preemphasis_level_strap  = tieLevel[5:4];
	assign output_termination_strap = tieLevel[6];
	assign output_current_strap     = tieLevel[7];
endmodule

//--- tb_switch_pin_strap_config.sv
// Purpose: self-checking bench of the strap configuration block.
// Assumes: one wait state on APB; controls lag the straps by one flop.
// Notes:   expected controls come from a queue of applied settings.
`timescale 1ns/100ps
module tb_switch_pin_strap_config;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [3:0]  pstrb, hsSourceSelect, auxCommonPortSel, termPulseEnable;
	logic [15:0] eqHighLane;
	logic [1:0]  preEmphasisLevel, srcStrap, peStrap;
	logic [7:0]  tieLevel, lvl;
	logic        strapModeActive, hsChannelEnable, standbyMode, auxSwitchEnable;
	logic        inputTermOn, outputTermOn, outputCurrentHigh;
	logic        enStrap, eqStrap, otoStrap, oclStrap;
	int          err_count, num_checks;
	int          hist[$];

	swp_strap_board board (.tieLevel(tieLevel), .hs_channel_enable_strap(enStrap),
		.source_select_strap(srcStrap), .equalizer_level_strap(eqStrap),
		.preemphasis_level_strap(peStrap), .output_termination_strap(otoStrap),
		.output_current_strap(oclStrap));

	swp_strap_cfg uut (.ref_clk(ref_clk), .rst_n(rst_n), .hs_channel_enable_strap(enStrap),
		.source_select_strap(srcStrap), .equalizer_level_strap(eqStrap),
		.preemphasis_level_strap(peStrap), .output_termination_strap(otoStrap),
		.output_current_strap(oclStrap), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strapModeActive(strapModeActive),
		.hsChannelEnable(hsChannelEnable), .standbyMode(standbyMode),
		.hsSourceSelect(hsSourceSelect), .auxCommonPortSel(auxCommonPortSel),
		.auxSwitchEnable(auxSwitchEnable), .inputTermOn(inputTermOn),
		.termPulseEnable(termPulseEnable), .eqHighLane(eqHighLane),
		.preEmphasisLevel(preEmphasisLevel), .outputTermOn(outputTermOn),
		.outputCurrentHigh(outputCurrentHigh));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// sample after the falling edge so flop updates have landed
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge ref_clk);
			if (pready === 1'b1)
				break;
		end
		if (n == 20)
		begin
			err_count++;
			complete_run();
		end
		else
		begin
			rd = prdata;
			err = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	// model: controls follow the low byte of the newest queued setting
	task automatic expect_cfg();
		int c;
		c = hist[$];
		check(hsChannelEnable, c & 1);
		check(standbyMode, ~c & 1);
		check(hsSourceSelect, 1 << ((c >> 1) & 3));
		check(auxCommonPortSel, 1 << ((c >> 1) & 3));
		check(auxSwitchEnable, 1);
		check(inputTermOn, 1);
		check(termPulseEnable, 0);
		check(eqHighLane, ((c >> 3) & 1) ? 16'hffff : 0);
		check(preEmphasisLevel, (c >> 4) & 3);
		check(outputTermOn, (c >> 6) & 1);
		check(outputCurrentHigh, (c >> 7) & 1);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0000_0000; pstrb = 4'hf;
		tieLevel = 8'h00; seed = 32'h0e8152a6; err_count = 0; num_checks = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		settle(1);
		check(strapModeActive, 1);
		// every source and pre-emphasis code, strap edits without reset
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr_next(seed);
			lvl = {seed[7:6], i[3:2], seed[3], i[1:0], i[0] ~^ i[2]};
			@(posedge ref_clk);
			tieLevel <= lvl;
			hist.push_back(lvl);
			settle(2);
			expect_cfg();
		end
		apb(1'b0, swp_pkg::OFS_STATUS, 32'h0000_0000);
		check(err, 0);
		check(rd, {5'h00, 3'b011, lvl, 15'h0000, 1'b1});
		settle(1);
		check(strapModeActive, 0);
		// straps now ignored: outputs must hold
		@(posedge ref_clk);
		tieLevel <= ~lvl;
		settle(3);
		expect_cfg();
		apb(1'b0, 12'h100, 32'h0000_0000);
		check(err, 1);
		check(rd, 0);
		seed = lfsr_next(seed);
		apb(1'b1, swp_pkg::OFS_CTRL, {21'h0, 3'b011, seed[7:0]});
		hist.push_back(seed[7:0]);
		settle(2);
		expect_cfg();
		apb(1'b0, swp_pkg::OFS_CTRL, 32'h0000_0000);
		check(rd, {21'h0, 3'b011, seed[7:0]});
		// low byte strobe only: the upper bits offered here must not land
		seed = lfsr_next(seed);
		pstrb <= 4'h1;
		apb(1'b1, swp_pkg::OFS_CTRL, {16'hffff, 8'hfc, seed[7:0]});
		pstrb <= 4'hf;
		hist.push_back(seed[7:0]);
		settle(2);
		expect_cfg();
		apb(1'b0, swp_pkg::OFS_CTRL, 32'h0000_0000);
		check(rd, {21'h0, 3'b011, seed[7:0]});
		// second reset brings strap mode back with the current ties
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		hist.push_back(tieLevel);
		settle(2);
		check(strapModeActive, 1);
		expect_cfg();
		complete_run();
	end
endmodule
